// ===== verilog/crc_clock_reset_tail.sv
`timescale 1ns/1ns
`default_nettype none
`include "crc_params.svh"
// Notes on behaviour
// - ext slow ready drops six osc cycles later
// - ext slow enable resets off
// - backup bits writable only when unlocked
// - backup bits cleared only by backup reset
// - sticky flag per reset cause
// - writing one clears all reset flags
// - power-on flag resets to one
// - int slow ready drops three cycles later
// - int slow enable resets off
// - mac, usb resets set-only; camera read-only
// - usb 48m source and phy pll on
// - usb phy reference frequency code
// - usb phy reference source select
// - usb phy prescale is value plus one
// - gigabit clock gate and source select
// - rng and audio clock source select
// - third multiplier writable only loop disabled
// - second multiplier writable only loop disabled
// - second prescaler writable both loops disabled
// - first prescaler writable main loop disabled
// - first prescaler bit0 mirrors primary bit17
module crc_clock_reset_tail
  import crc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        backup_rst,
  input  wire logic        power_on_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        backup_write_unlock,
  input  wire logic        ext_slow_osc_clk,
  input  wire logic        int_slow_osc_clk,
  input  wire logic        lowpower_reset_evt,
  input  wire logic        window_dog_reset_evt,
  input  wire logic        indep_dog_reset_evt,
  input  wire logic        soft_reset_evt,
  input  wire logic        external_reset_pin_evt,
  input  wire logic        main_loop_on,
  input  wire logic        second_loop_on,
  input  wire logic        third_loop_on,
  input  wire logic        primary_bit17,
  input  wire logic        camera_if_block_reset,
  output logic             ext_slow_osc_on,
  output logic             ext_slow_osc_bypass,
  output logic      [1:0]  rtc_source_select,
  output logic             rtc_clock_gate,
  output logic             int_slow_osc_on,
  output logic             ether_mac_block_reset,
  output logic             usb_fullspeed_block_reset,
  output logic             primary_bit17_wr,
  output logic             primary_bit17_val,
  output logic      [31:0] clock_config_ext
);
  logic        ext_on_r, ext_byp_r, gate_r;
  logic [1:0]  sel_r;
  logic        int_on_r;
  logic [5:0]  flags_r;
  logic        mac_r, usb_r;
  logic [31:0] cfg2_r;
  logic        ev_s1_r [5];
  logic        ev_s2_r [5];
  logic        ext_rdy, int_rdy;
  logic [31:0] cfg2_nxt;

  wire wr       = psel & penable & pwrite;
  wire hit_bdc  = (paddr == `CRC_OFS_BDC);
  wire hit_rsc  = (paddr == `CRC_OFS_RSC);
  wire hit_ahb  = (paddr == `CRC_OFS_AHB_RST);
  wire hit_cfg2 = (paddr == `CRC_OFS_CFG2);
  wire wr_bdc   = wr & hit_bdc & backup_write_unlock;
  wire wr_rsc   = wr & hit_rsc;
  wire wr_ahb   = wr & hit_ahb;
  wire wr_cfg2  = wr & hit_cfg2;
  wire clr_flags = wr_rsc & pwdata[`CRC_RSC_CLR_BIT];
  wire [5:0] ev_now = {ev_s2_r[0], ev_s2_r[1], ev_s2_r[2], ev_s2_r[3], 1'b0, ev_s2_r[4]};

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  crc_osc_ready #(.OFF_CYCLES(`CRC_EXT_OFF_CYC)) u_ext_rdy (
    .sys_clk     (sys_clk),
    .sys_rst     (backup_rst),
    .osc_on      (ext_on_r),
    .osc_clk_pin (ext_slow_osc_clk),
    .osc_ready   (ext_rdy)
  );
  crc_osc_ready #(.OFF_CYCLES(`CRC_INT_OFF_CYC)) u_int_rdy (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .osc_on      (int_on_r),
    .osc_clk_pin (int_slow_osc_clk),
    .osc_ready   (int_rdy)
  );

  // backup bits ignore system reset, only backup_rst clears them
  always_ff @(posedge sys_clk) begin
    if (backup_rst) begin
      ext_on_r  <= 1'b0;
      ext_byp_r <= 1'b0;
      sel_r     <= 2'b00;
      gate_r    <= 1'b0;
    end else if (wr_bdc) begin
      ext_on_r <= pwdata[`CRC_BDC_ON_BIT];
      // bypass only changes while oscillator off
      if (!ext_on_r) ext_byp_r <= pwdata[`CRC_BDC_BYP_BIT];
      // source locked once the gate is on
      if (!gate_r) sel_r <= pwdata[`CRC_BDC_SEL_LO +: 2];
      gate_r <= pwdata[`CRC_BDC_GATE_BIT] & (pwdata[`CRC_BDC_SEL_LO +: 2] != 2'b00 | sel_r != 2'b00 & gate_r);
    end
  end

  // flags survive system reset; hold pulses synced, set beats clear
  always_ff @(posedge sys_clk) begin
    if (power_on_rst) begin
      flags_r <= `CRC_RSC_FLAGS_RST;
    end else begin
      flags_r <= (clr_flags ? 6'h00 : flags_r) | ev_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (power_on_rst) begin
      for (int i = 0; i < 5; i++) begin
        ev_s1_r[i] <= 1'b0;
        ev_s2_r[i] <= 1'b0;
      end
    end else begin
      ev_s1_r[0] <= lowpower_reset_evt;
      ev_s1_r[1] <= window_dog_reset_evt;
      ev_s1_r[2] <= indep_dog_reset_evt;
      ev_s1_r[3] <= soft_reset_evt;
      ev_s1_r[4] <= external_reset_pin_evt;
      for (int i = 0; i < 5; i++) ev_s2_r[i] <= ev_s1_r[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_on_r <= 1'b0;
      mac_r    <= 1'b0;
      usb_r    <= 1'b0;
    end else begin
      if (wr_rsc) int_on_r <= pwdata[`CRC_RSC_ON_BIT];
      // set-only; the block reset stays until system reset
      if (wr_ahb && pwdata[`CRC_AHB_MAC_BIT]) mac_r <= 1'b1;
      if (wr_ahb && pwdata[`CRC_AHB_USB_BIT]) usb_r <= 1'b1;
    end
  end

  // field write guards against running loops
  always_comb begin
    cfg2_nxt = cfg2_r;
    if (wr_cfg2) begin
      cfg2_nxt[31:16] = pwdata[31:16] & 16'(`CRC_CFG2_MASK >> 16);
      if (!third_loop_on) cfg2_nxt[15:12] = pwdata[15:12];
      if (!second_loop_on) cfg2_nxt[11:8] = pwdata[11:8];
      if (!second_loop_on && !third_loop_on) cfg2_nxt[7:4] = pwdata[7:4];
      if (!main_loop_on) cfg2_nxt[3:0] = pwdata[3:0];
    end
    // pure mirror; a write with the main loop off is forwarded to the primary register instead
    cfg2_nxt[0] = primary_bit17;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) cfg2_r <= 32'h0000_0000;
    else         cfg2_r <= cfg2_nxt;
  end

  assign primary_bit17_wr  = wr_cfg2 & ~main_loop_on;
  assign primary_bit17_val = pwdata[0];

  wire [31:0] rd_bdc = {15'h0000, 1'b0, gate_r, 5'h00, sel_r, 5'h00, ext_byp_r, ext_rdy, ext_on_r};
  wire [31:0] rd_rsc = {flags_r, 1'b0, 1'b0, 22'h000000, int_rdy, int_on_r};
  wire [31:0] rd_ahb = {17'h00000, mac_r, camera_if_block_reset, usb_r, 12'h000};
  wire [31:0] rd_mux = hit_bdc ? rd_bdc :
                       hit_rsc ? rd_rsc :
                       hit_ahb ? rd_ahb :
                       hit_cfg2 ? cfg2_r : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  assign ext_slow_osc_on           = ext_on_r;
  assign ext_slow_osc_bypass       = ext_byp_r;
  assign rtc_source_select         = sel_r;
  assign rtc_clock_gate            = gate_r;
  assign int_slow_osc_on           = int_on_r;
  assign ether_mac_block_reset     = mac_r;
  assign usb_fullspeed_block_reset = usb_r;
  assign clock_config_ext          = cfg2_r;
endmodule : crc_clock_reset_tail
`default_nettype wire

// ===== pkg/crc_params.svh
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH
`define CRC_OFS_AHB_RST      8'h28
`define CRC_OFS_BDC          8'h20
`define CRC_OFS_RSC          8'h24
`define CRC_OFS_CFG2         8'h2c
`define CRC_OFS_PLL_CTRL     8'h30
`define CRC_BDC_ON_BIT       0
`define CRC_BDC_RDY_BIT      1
`define CRC_BDC_BYP_BIT      2
`define CRC_BDC_SEL_LO       8
`define CRC_BDC_GATE_BIT     15
`define CRC_BDC_RST_BIT      16
`define CRC_RSC_ON_BIT       0
`define CRC_RSC_RDY_BIT      1
`define CRC_RSC_CLR_BIT      24
`define CRC_RSC_PIN_BIT      26
`define CRC_RSC_FLAG_LO      26
`define CRC_AHB_USB_BIT      12
`define CRC_AHB_CAM_BIT      13
`define CRC_AHB_MAC_BIT      14
`define CRC_CFG2_MASK        32'hff7fffff
`define CRC_RSC_FLAGS_RST    6'h02
`define CRC_EXT_OFF_CYC      6
`define CRC_INT_OFF_CYC      3
`endif

// ===== pkg/crc_pkg.sv
package crc_pkg;
  typedef enum logic [1:0] {
    CRC_OSC_OFF   = 2'b00,
    CRC_OSC_READY = 2'b01,
    CRC_OSC_DRAIN = 2'b10
  } crc_osc_state_t;
  typedef logic [31:0] crc_word_t;
endpackage : crc_pkg

// ===== verilog/crc_osc_ready.sv
`timescale 1ns/1ns
`default_nettype none
module crc_osc_ready
  import crc_pkg::*;
#(
  parameter int OFF_CYCLES = 6
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic osc_on,
  input  wire logic osc_clk_pin,
  output logic      osc_ready
);
  logic           sync1_r;
  logic           sync2_r;
  logic           prev_r;
  logic [3:0]     cnt_r;
  crc_osc_state_t state_r;
  wire            osc_edge = sync2_r & ~prev_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= osc_clk_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ready rises on first oscillator edge after enabling
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= CRC_OSC_OFF;
      cnt_r   <= 4'h0;
    end else begin
      case (state_r)
        CRC_OSC_OFF: begin
          if (osc_on && osc_edge) state_r <= CRC_OSC_READY;
        end
        CRC_OSC_READY: begin
          cnt_r <= 4'h0;
          if (!osc_on) state_r <= CRC_OSC_DRAIN;
        end
        CRC_OSC_DRAIN: begin
          if (osc_on) begin
            state_r <= CRC_OSC_READY;
          end else if (osc_edge) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(OFF_CYCLES - 1)) state_r <= CRC_OSC_OFF;
          end
        end
        default: state_r <= CRC_OSC_OFF;
      endcase
    end
  end

  assign osc_ready = (state_r != CRC_OSC_OFF);
endmodule : crc_osc_ready
`default_nettype wire

// ===== verification/crc_props.sv
`timescale 1ns/1ns
`default_nettype none
module crc_props
  import crc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        backup_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        backup_write_unlock,
  input wire logic        second_loop_on,
  input wire logic        third_loop_on,
  input wire logic        ext_slow_osc_on,
  input wire logic [1:0]  rtc_source_select,
  input wire logic        ether_mac_block_reset,
  input wire logic        usb_fullspeed_block_reset,
  input wire logic [31:0] clock_config_ext,
  input wire logic        main_loop_on,
  input wire logic        primary_bit17_wr,
  input wire logic        primary_bit17_val
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire bwr = acc && pwrite && paddr == 8'h20 && !backup_rst;
  wire cwr = acc && pwrite && paddr == 8'h2c;
  bkp_unlock_a: assert property (
    bwr && backup_write_unlock |=> ext_slow_osc_on == $past(pwdata[0])) else $error("bkp write");
  bkp_lock_a: assert property (
    bwr && !backup_write_unlock |=> $stable({ext_slow_osc_on, rtc_source_select}))
    else $error("bkp lock");
  // own disable: system reset is exactly the cause here
  bkp_keep_a: assert property (@(posedge sys_clk) disable iff (backup_rst)
    sys_rst |=> $stable({ext_slow_osc_on, rtc_source_select})) else $error("bkp kept");
  mac_set_a: assert property (
    acc && pwrite && paddr == 8'h28 |=> ether_mac_block_reset ==
    ($past(pwdata[14]) || $past(ether_mac_block_reset))) else $error("mac rst");
  usb_keep_a: assert property (
    $fell(usb_fullspeed_block_reset) |-> $past(sys_rst)) else $error("usb rst");
  mul3_lock_a: assert property (
    cwr && third_loop_on |=> $stable(clock_config_ext[15:12])) else $error("mul3");
  mul2_lock_a: assert property (
    $changed(clock_config_ext[11:8]) |-> $past(cwr) && !$past(second_loop_on))
    else $error("mul2");
  div2_lock_a: assert property (
    cwr && (second_loop_on || third_loop_on) |=> $stable(clock_config_ext[7:4]))
    else $error("div2");
  rsvd_read_a: assert property (
    acc && !pwrite && paddr < 8'h20 |-> prdata == 32'h0) else $error("unmapped");
  cfg_rsvd_a: assert property (!clock_config_ext[23]) else $error("cfg rsvd");
  mirror_fwd_a: assert property (primary_bit17_wr == (cwr && !main_loop_on))
    else $error("mirror fwd");
  mirror_val_a: assert property (primary_bit17_wr |-> primary_bit17_val == pwdata[0])
    else $error("mirror val");
  cover property (bwr && backup_write_unlock);
  cover property (cwr && third_loop_on);
  cover property ($rose(ether_mac_block_reset));
endmodule : crc_props
bind crc_clock_reset_tail crc_props u_props (.sys_clk, .sys_rst, .backup_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .backup_write_unlock, .second_loop_on,
  .third_loop_on, .ext_slow_osc_on, .rtc_source_select, .ether_mac_block_reset,
  .usb_fullspeed_block_reset, .clock_config_ext, .main_loop_on, .primary_bit17_wr,
  .primary_bit17_val);
`default_nettype wire

// ===== verification/test_clock_reset_config_tail.sv
`timescale 1ns/1ns
`default_nettype none
module test_clock_reset_config_tail;
  logic        sys_clk = 0, sys_rst = 1, backup_rst = 1, power_on_rst = 1;
  logic        psel = 0, penable = 0, pwrite = 0, unlock = 0, prim = 0, cam = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, ex, seed = 32'hfd03;
  logic [4:0]  evt = 0;
  logic [2:0]  lp = 0;
  logic [3:0]  dv = 0;
  wire  [31:0] prdata, cfg;
  wire         pready, mac, usb;
  int          bad_count = 0, tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  // slow clocks from a divider: 8 and 16 cycle periods
  always @(posedge sys_clk) dv <= dv + 4'h1;
  crc_clock_reset_tail u_dut (.sys_clk, .sys_rst, .backup_rst, .power_on_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .backup_write_unlock(unlock), .ext_slow_osc_clk(dv[2]), .int_slow_osc_clk(dv[3]),
    .lowpower_reset_evt(evt[4]), .window_dog_reset_evt(evt[3]), .indep_dog_reset_evt(evt[2]),
    .soft_reset_evt(evt[1]), .external_reset_pin_evt(evt[0]), .main_loop_on(lp[0]),
    .second_loop_on(lp[1]), .third_loop_on(lp[2]), .primary_bit17(prim),
    .camera_if_block_reset(cam), .ext_slow_osc_on(), .ext_slow_osc_bypass(),
    .rtc_source_select(), .rtc_clock_gate(), .int_slow_osc_on(), .ether_mac_block_reset(mac),
    .usb_fullspeed_block_reset(usb), .primary_bit17_wr(), .primary_bit17_val(),
    .clock_config_ext(cfg));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] wm(input logic [2:0] l);
    return 32'hfffffffe & ~{16'h0, {4{l[2]}}, {4{l[1]}}, {4{l[1] | l[2]}}, {3{l[0]}}, 1'b0};
  endfunction : wm
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 16) begin
      bad_count++;
      report_and_stop;
    end
  endtask : apb
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e & m, rd & m);
  endtask : rdc
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  initial begin
    tick(12);
    {sys_rst, backup_rst, power_on_rst} <= 3'b000;
    rdc("cause", 8'h24, '1, 32'h08000000);
    rdc("bdc", 8'h20, '1, 32'h0);
    apb(1'b1, 8'h10, '1);
    rdc("unmapped", 8'h10, '1, 32'h0);
    apb(1'b1, 8'h20, 32'h0000ffff);
    rdc("locked", 8'h20, '1, 32'h0);
    unlock <= 1'b1;
    apb(1'b1, 8'h20, 32'h00008101);
    apb(1'b1, 8'h24, 32'h00000001);
    tick(40);
    rdc("bdc_on", 8'h20, '1, 32'h00008103);
    rdc("lsi_on", 8'h24, 32'h3, 32'h3);
    apb(1'b1, 8'h20, 32'h00008100);
    apb(1'b1, 8'h24, 32'h0);
    tick(16);
    rdc("lse_hold", 8'h20, 32'h2, 32'h2);
    rdc("lsi_hold", 8'h24, 32'h2, 32'h2);
    tick(48);
    rdc("lse_off", 8'h20, 32'h2, 32'h0);
    rdc("lsi_off", 8'h24, 32'h2, 32'h0);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    rdc("keep", 8'h20, '1, 32'h00008100);
    backup_rst <= 1'b1;
    tick(2);
    backup_rst <= 1'b0;
    rdc("bkp_clr", 8'h20, '1, 32'h0);
    ex = 32'h08000000;
    for (int i = 0; i < 5; i++) begin
      evt <= 5'h1 << i;
      tick(4);
      evt <= 5'h0;
      tick(4);
      ex |= (i == 0) ? 32'h04000000 : 32'h08000000 << i;
      rdc("flags", 8'h24, 32'hfc000000, ex);
    end
    apb(1'b1, 8'h24, 32'h0);
    rdc("noclr", 8'h24, 32'hfc000000, 32'hfc000000);
    apb(1'b1, 8'h24, 32'h01000000);
    rdc("clr", 8'h24, 32'hfc000000, 32'h0);
    cam <= 1'b1;
    apb(1'b1, 8'h28, 32'hffffbfff);
    rdc("ahb1", 8'h28, '1, 32'h00003000);
    apb(1'b1, 8'h28, 32'h00004000);
    apb(1'b1, 8'h28, 32'h0);
    rdc("ahb2", 8'h28, '1, 32'h00007000);
    chk("blkrst", 32'h3, {30'h0, mac, usb});
    ex = 32'h0;
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      lp <= seed[31:29];
      prim <= seed[28];
      apb(1'b1, 8'h2c, seed);
      ex = (ex & ~wm(seed[31:29])) | (seed & wm(seed[31:29])) & 32'hff7fffff;
      chk("cfg2", ex, cfg & 32'hfffffffe);
      chk("mirror", {31'h0, prim}, {31'h0, cfg[0]});
    end
    rdc("cfg2_rd", 8'h2c, '1, ex | {31'h0, prim});
    report_and_stop;
  end
endmodule : test_clock_reset_config_tail
`default_nettype wire
